// *** verilog/fan_ctrl.v ***
/*
 Two-fan automatic speed control: temperature curve, overrides, ceiling,
 over-temperature override, stepped drive, spin-up retry and lock pin,
 board-test XOR output, and an 8-bit register port.
 Assumes temperatures and tach inputs synchronous to ref_clk.
*/
// Design decision made here: the strobed register port.
`timescale 1ns/10ps
`include "fan_ctrl_defines.vh"

module fan_ctrl #(
  parameter MS_CYC = `MS_NS / `CLK_NS
) (
  input wire ref_clk,
  input wire sys_rst,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr_en,
  input wire rd_en,
  output reg [7:0] rdata,
  input wire [7:0] thermistor_in_1,
  input wire [7:0] thermistor_in_2,
  input wire [7:0] remote_temp_1,
  input wire [7:0] local_temp,
  input wire tach_in_1,
  input wire tach_in_2,
  input wire processor_hot_input,
  output wire [7:0] drive_out_1,
  output wire [7:0] drive_out_2,
  output reg fan1_power_on,
  output reg stall_fault_pin,
  output reg tree_test_out
);

  localparam ST_OFF = 2'd0;
  localparam ST_START = 2'd1;
  localparam ST_RUN = 2'd2;
  localparam ST_WAIT = 2'd3;

  // ==========================================================
  // Registers
  reg [7:0] loop_cfg_r [0:1];
  reg [7:0] ceil_r [0:1];
  reg [7:0] start_r [0:1];
  reg [7:0] hold_r [0:1];
  reg [7:0] floor_r [0:1];
  reg [7:0] span_r [0:1];
  reg [7:0] man_r [0:1];
  reg [7:0] conf4_r, acou_r, tout_r, ppr_r, test_r;
  reg [7:0] otlim_r, othyst_r, offhyst_r, rstep_r;
  reg [1:0] stat_r;
  reg ot_r;
  reg [15:0] ms_cnt_r;
  reg ms_tick_r;
  reg [7:0] q_cnt_r;
  reg q_tick_r;
  wire [7:0] temp [0:3];
  wire [1:0] tach;
  wire [1:0] fault_set;
  wire [1:0] lock;
  wire [7:0] drv [0:1];
  wire [1:0] st [0:1];

  assign temp[0] = thermistor_in_1;
  assign temp[1] = thermistor_in_2;
  assign temp[2] = remote_temp_1;
  assign temp[3] = local_temp;
  assign tach = {tach_in_2, tach_in_1};

  function [15:0] tout_ms;
    input [2:0] code;
    begin
      case (code)
        3'd1: tout_ms = 16'd100;
        3'd2: tout_ms = 16'd250;
        3'd3: tout_ms = 16'd400;
        3'd4: tout_ms = 16'd667;
        3'd5: tout_ms = 16'd1000;
        3'd6: tout_ms = 16'd2000;
        3'd7: tout_ms = 16'd4000;
        default: tout_ms = 16'd0;
      endcase
    end
  endfunction

  function [7:0] step_size;
    input [2:0] code;
    begin
      case (code)
        3'd0: step_size = 8'h01;
        3'd1: step_size = 8'h02;
        3'd2: step_size = 8'h03;
        3'd3: step_size = 8'h05;
        3'd4: step_size = 8'h08;
        3'd5: step_size = 8'h0C;
        3'd6: step_size = 8'h18;
        default: step_size = 8'h30;
      endcase
    end
  endfunction

  function [7:0] curve;
    input [7:0] t;
    input [7:0] fl;
    input [7:0] sp;
    input [7:0] hl;
    reg [7:0] d;
    reg [15:0] q;
    begin
      d = t - fl;
      q = ({8'h00, d} * {8'h00, `FULL - hl}) / {8'h00, sp};
      if (t <= fl)
        curve = 8'h00;
      else if (sp == 8'h00 || d >= sp)
        curve = `FULL;
      else
        curve = hl + q[7:0];
    end
  endfunction

  // ==========================================================
  // Time base
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      ms_cnt_r <= 16'h0000;
      ms_tick_r <= 1'b0;
      q_cnt_r <= 8'h00;
      q_tick_r <= 1'b0;
    end else begin
      ms_tick_r <= (ms_cnt_r == MS_CYC - 1);
      ms_cnt_r <= (ms_cnt_r == MS_CYC - 1) ? 16'h0000 : ms_cnt_r + 16'h0001;
      q_tick_r <= 1'b0;
      if (ms_tick_r) begin
        if (q_cnt_r == `LOOP_MS - 1) begin
          q_cnt_r <= 8'h00;
          q_tick_r <= 1'b1;
        end else begin
          q_cnt_r <= q_cnt_r + 8'h01;
        end
      end
    end
  end

  // ==========================================================
  // Over-temperature latch
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      ot_r <= 1'b0;
    end else if (temp[0] >= otlim_r || temp[1] >= otlim_r || temp[2] >= otlim_r || temp[3] >= otlim_r) begin
      ot_r <= 1'b1; // RULE11
    end else if ({1'b0, temp[0]} + {1'b0, othyst_r} < {1'b0, otlim_r} &&
                 {1'b0, temp[1]} + {1'b0, othyst_r} < {1'b0, otlim_r} &&
                 {1'b0, temp[2]} + {1'b0, othyst_r} < {1'b0, otlim_r} &&
                 {1'b0, temp[3]} + {1'b0, othyst_r} < {1'b0, otlim_r}) begin
      ot_r <= 1'b0; // RULE11
    end
  end

  // ==========================================================
  // Per-fan control
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : gf
      reg [1:0] st_r;
      reg [7:0] drv_r;
      reg [7:0] auto_r;
      reg [7:0] cur_start_r;
      reg [2:0] retry_r;
      reg [15:0] cnt_r;
      reg [2:0] edges_r;
      reg tach_d_r;
      reg lock_r;
      reg fault_r;
      reg [7:0] tgt;
      reg [7:0] c;
      reg hot;
      reg cold;
      reg [7:0] drv_nxt;
      reg [7:0] lim;
      reg [8:0] bump;
      integer k;
      wire [7:0] cfg = loop_cfg_r[i];
      wire auto_mode = (cfg[7:4] == 4'h0);
      wire rise = tach[i] & ~tach_d_r;
      wire [2:0] need = {1'b0, ppr_r[2*i+1:2*i]} + 3'd1;
      wire [15:0] tout = tout_ms(tout_r[3*i+2:3*i]);
      wire [7:0] stp = step_size(acou_r[3*i+2:3*i]);

      // Demand from the selected sources
      always @* begin
        tgt = 8'h00;
        hot = 1'b0;
        cold = 1'b1;
        c = 8'h00;
        for (k = 0; k < 4; k = k + 1) begin
          if (cfg[k]) begin // RULE3
            c = curve(temp[k], floor_r[i], span_r[i], hold_r[i]); // RULE12
            if (c > tgt)
              tgt = c; // RULE4
            if (temp[k] > floor_r[i])
              hot = 1'b1;
            if ({1'b0, temp[k]} + {1'b0, offhyst_r} >= {1'b0, floor_r[i]})
              cold = 1'b0;
          end
        end
        if (tgt < hold_r[i])
          tgt = hold_r[i]; // RULE16
      end

      // Output selection by priority
      always @* begin
        lim = (ceil_r[i] != 8'h00 && auto_r > ceil_r[i]) ? ceil_r[i] : auto_r; // RULE10
        bump = {1'b0, cur_start_r} + {1'b0, rstep_r};
        if (ot_r)
          drv_nxt = `FULL; // RULE11
        else if (cfg[`B_MAX])
          drv_nxt = `FULL; // RULE8
        else if (cfg[`B_STRT])
          drv_nxt = start_r[i]; // RULE7
        else if (cfg[`B_MIN])
          drv_nxt = hold_r[i]; // RULE6
        else if (cfg[`B_MAN])
          drv_nxt = man_r[i]; // RULE5
        else if (st_r == ST_START)
          drv_nxt = cur_start_r; // RULE15
        else if (st_r == ST_RUN)
          drv_nxt = lim;
        else
          drv_nxt = 8'h00; // RULE20
      end

      always @(posedge ref_clk) begin
        if (sys_rst) begin
          st_r <= ST_OFF;
          drv_r <= 8'h00;
          auto_r <= 8'h00;
          cur_start_r <= 8'h00;
          retry_r <= 3'd0;
          cnt_r <= 16'h0000;
          edges_r <= 3'd0;
          tach_d_r <= 1'b1;
          lock_r <= 1'b0;
          fault_r <= 1'b0;
        end else begin
          tach_d_r <= tach[i];
          drv_r <= drv_nxt;
          fault_r <= 1'b0;
          if (!auto_mode) begin
            st_r <= ST_OFF;
            lock_r <= 1'b0;
          end else begin
            case (st_r)
              ST_OFF: begin
                if (hot) begin
                  st_r <= ST_START; // RULE15
                  cur_start_r <= start_r[i];
                  retry_r <= 3'd0;
                  cnt_r <= 16'h0000; // RULE24
                  edges_r <= 3'd0;
                end
              end
              ST_START: begin
                if (rise)
                  edges_r <= edges_r + 3'd1; // RULE23
                if (ms_tick_r)
                  cnt_r <= cnt_r + 16'h0001;
                if (ms_tick_r && tout != 16'h0000 && cnt_r + 16'h0001 == tout && edges_r < need)
                  fault_r <= 1'b1; // RULE1
                if (edges_r >= need) begin
                  st_r <= ST_RUN; // RULE15
                  auto_r <= hold_r[i];
                  lock_r <= 1'b0;
                  cnt_r <= 16'h0000; // RULE24
                end else if (ms_tick_r && cnt_r == `RETRY_MS - 1) begin
                  cnt_r <= 16'h0000;
                  edges_r <= 3'd0;
                  if (retry_r < `MAX_RETRY && cur_start_r != `FULL) begin
                    retry_r <= retry_r + 3'd1; // RULE19
                    cur_start_r <= bump[8] ? `FULL : bump[7:0];
                  end else begin
                    lock_r <= 1'b1; // RULE19
                    st_r <= ST_WAIT; // RULE20
                  end
                end
              end
              ST_RUN: begin
                if (cold && !conf4_r[`B_MINBIT + i]) begin
                  st_r <= ST_OFF; // RULE16
                  auto_r <= 8'h00;
                end else if (q_tick_r) begin // RULE18
                  if (!acou_r[`B_STEPEN + i]) // RULE14
                    auto_r <= tgt;
                  else if (auto_r < tgt)
                    auto_r <= (tgt - auto_r > stp) ? auto_r + stp : tgt; // RULE13
                  else
                    auto_r <= (auto_r - tgt > stp) ? auto_r - stp : tgt; // RULE13
                end
              end
              ST_WAIT: begin
                if (ms_tick_r)
                  cnt_r <= cnt_r + 16'h0001;
                if (ms_tick_r && cnt_r == `WAIT_MS - 1) begin
                  cnt_r <= 16'h0000;
                  st_r <= ST_OFF; // RULE20
                end
              end
              default: st_r <= ST_OFF;
            endcase
          end
        end
      end

      assign fault_set[i] = fault_r;
      assign lock[i] = lock_r;
      assign drv[i] = drv_r;
      assign st[i] = st_r;
    end
  endgenerate

  assign drive_out_1 = drv[0];
  assign drive_out_2 = drv[1];

  // ==========================================================
  // Pins
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      fan1_power_on <= 1'b0;
      stall_fault_pin <= 1'b0;
      tree_test_out <= 1'b0;
    end else begin
      fan1_power_on <= (gf[0].drv_nxt != 8'h00); // RULE15 RULE17
      stall_fault_pin <= |lock; // RULE19
      tree_test_out <= test_r[`B_TREE] & (tach_in_1 ^ tach_in_2 ^ processor_hot_input); // RULE21
    end
  end

  // ==========================================================
  // Register port
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      loop_cfg_r[0] <= `R_LOOP;
      loop_cfg_r[1] <= `R_LOOP;
      ceil_r[0] <= 8'h00;
      ceil_r[1] <= 8'h00;
      start_r[0] <= `R_START;
      start_r[1] <= `R_START;
      hold_r[0] <= `R_HOLD;
      hold_r[1] <= `R_HOLD;
      floor_r[0] <= `R_FLOOR;
      floor_r[1] <= `R_FLOOR;
      span_r[0] <= `R_SPAN;
      span_r[1] <= `R_SPAN;
      man_r[0] <= 8'h00;
      man_r[1] <= 8'h00;
      conf4_r <= 8'h00;
      acou_r <= 8'h00;
      tout_r <= 8'h00;
      ppr_r <= `R_PPR;
      test_r <= 8'h00;
      otlim_r <= `R_OTLIM;
      othyst_r <= `R_HYST;
      offhyst_r <= `R_HYST;
      rstep_r <= `R_RSTEP;
    end else if (wr_en) begin
      case (addr)
        `A_CONF4: conf4_r <= wdata;
        `A_LOOP1: loop_cfg_r[0] <= wdata;
        `A_LOOP2: loop_cfg_r[1] <= wdata;
        `A_CEIL1: ceil_r[0] <= wdata;
        `A_CEIL2: ceil_r[1] <= wdata;
        `A_ACOU: acou_r <= wdata;
        `A_TOUT: tout_r <= {2'b00, wdata[5:0]}; // RULE2
        `A_PPR: ppr_r <= {4'h0, wdata[3:0]};
        `A_TEST: test_r <= {7'h00, wdata[0]};
        `A_START1: start_r[0] <= wdata;
        `A_START2: start_r[1] <= wdata;
        `A_HOLD1: hold_r[0] <= wdata;
        `A_HOLD2: hold_r[1] <= wdata;
        `A_FLOOR1: floor_r[0] <= wdata;
        `A_FLOOR2: floor_r[1] <= wdata;
        `A_SPAN1: span_r[0] <= wdata;
        `A_SPAN2: span_r[1] <= wdata;
        `A_OTLIM: otlim_r <= wdata;
        `A_OTHYST: othyst_r <= wdata;
        `A_OFFHYST: offhyst_r <= wdata;
        `A_MAN1: man_r[0] <= wdata;
        `A_MAN2: man_r[1] <= wdata;
        `A_RSTEP: rstep_r <= wdata;
        default: conf4_r <= conf4_r;
      endcase
    end
  end

  // Status bits clear on read; a new fault in the same cycle wins
  always @(posedge ref_clk) begin
    if (sys_rst)
      stat_r <= 2'b00;
    else
      stat_r <= ((rd_en && addr == `A_STAT1) ? 2'b00 : stat_r) | {fault_set[0], fault_set[1]}; // RULE1
  end

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      rdata <= 8'h00;
    end else if (rd_en) begin
      case (addr)
        `A_CONF4: rdata <= conf4_r;
        `A_LOOP1: rdata <= loop_cfg_r[0];
        `A_LOOP2: rdata <= loop_cfg_r[1];
        `A_STAT1: rdata <= {6'h00, stat_r};
        `A_CEIL1: rdata <= ceil_r[0];
        `A_CEIL2: rdata <= ceil_r[1];
        `A_ACOU: rdata <= acou_r;
        `A_TOUT: rdata <= tout_r;
        `A_PPR: rdata <= ppr_r;
        `A_TEST: rdata <= test_r;
        `A_START1: rdata <= start_r[0];
        `A_START2: rdata <= start_r[1];
        `A_HOLD1: rdata <= hold_r[0];
        `A_HOLD2: rdata <= hold_r[1];
        `A_FLOOR1: rdata <= floor_r[0];
        `A_FLOOR2: rdata <= floor_r[1];
        `A_SPAN1: rdata <= span_r[0];
        `A_SPAN2: rdata <= span_r[1];
        `A_OTLIM: rdata <= otlim_r;
        `A_OTHYST: rdata <= othyst_r;
        `A_OFFHYST: rdata <= offhyst_r;
        `A_MAN1: rdata <= man_r[0];
        `A_MAN2: rdata <= man_r[1];
        `A_RSTEP: rdata <= rstep_r;
        `A_DRV1: rdata <= drv[0];
        `A_DRV2: rdata <= drv[1];
        `A_STATE: rdata <= {ot_r, lock, 1'b0, st[1], st[0]};
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule

// *** verilog/fan_ctrl_defines.vh ***
/*
 Constants of the two-fan automatic speed controller: register offsets,
 reset values, field positions and timing counts.
 Assumes a 50 MHz ref_clk and an 8-bit register port.
*/
//
// How it works
// RULE1 - Missed spin-up pulses within the chosen timeout set the fan fault status bit; the 4000 ms code never sets it, as the 2 s retry clears the count.
// RULE2 - Timeout codes 000..111 per fan: none, 100, 250, 400, 667, 1000, 2000, 4000 ms.
// RULE3 - Loop config per fan; bits 0..3 pick thermistor 1, thermistor 2, remote 1, local.
// RULE4 - Several selected sources: the one demanding the highest drive wins.
// RULE5 - Bit 4 gives manual control; the host-written drive value is used.
// RULE6 - Bit 5 holds the hold level, above bits 4..0.
// RULE7 - Bit 6 holds the start level, above bits 5..0.
// RULE8 - Bit 7 runs full drive, above bits 6..0.
// RULE9 - Host should zero both ceilings while fans are under manual drive.
// RULE10 - Run-state automatic drive never exceeds a nonzero ceiling; spin-up start level and over-temperature full drive are not limited.
// RULE11 - Over-temperature forces full drive until temperature falls below limit minus hysteresis.
// RULE12 - Above the floor drive rises linearly from hold level to full at floor plus span.
// RULE13 - Stepped mode moves automatic drive by the step size every 250 ms.
// RULE14 - Stepping enabled by acoustics bit 6 for fan 1 and bit 7 for fan 2.
// RULE15 - Crossing the floor outputs start level and fan 1 power-on; pulses lower to hold.
// RULE16 - Below floor hold level; below floor minus hysteresis off unless minimum bit set.
// RULE17 - Fan 1 power-on drops whenever fan 1 drive is zero.
// RULE18 - Automatic drive is recomputed every 250 ms.
// RULE19 - Too few pulses in 2 s: raise start level by step, retry five times, then lock pin.
// RULE20 - After a failed start drive zero, wait one minute, restart the sequence.
// RULE21 - Test enable bit 0 turns on the board-test XOR chain output.
// RULE22 - Host must set pin 7 hot-input config and hot mask before tree test.
// RULE23 - Spin-up counts tach rising edges; 2-bit code selects 1 to 4 pulses.
// RULE24 - Timeout counter starts when drive leaves zero, clears when rotation confirmed.
`ifndef FAN_CTRL_DEFINES_VH
`define FAN_CTRL_DEFINES_VH

// ==========================================================
// Register offsets
`define A_CONF4 8'h03
`define A_LOOP1 8'h05
`define A_LOOP2 8'h06
`define A_STAT1 8'h10
`define A_CEIL1 8'h34
`define A_CEIL2 8'h35
`define A_ACOU 8'h36
`define A_TOUT 8'h38
`define A_PPR 8'h39
`define A_TEST 8'h42
`define A_START1 8'h60
`define A_START2 8'h61
`define A_HOLD1 8'h62
`define A_HOLD2 8'h63
`define A_FLOOR1 8'h64
`define A_FLOOR2 8'h65
`define A_SPAN1 8'h66
`define A_SPAN2 8'h67
`define A_OTLIM 8'h68
`define A_OTHYST 8'h69
`define A_OFFHYST 8'h6A
`define A_MAN1 8'h6B
`define A_MAN2 8'h6C
`define A_RSTEP 8'h6D
`define A_DRV1 8'h70
`define A_DRV2 8'h71
`define A_STATE 8'h72

// ==========================================================
// Reset values
`define R_LOOP 8'h0C
`define R_PPR 8'h05
`define R_START 8'h80
`define R_HOLD 8'h40
`define R_FLOOR 8'h28
`define R_SPAN 8'h14
`define R_OTLIM 8'h64
`define R_HYST 8'h04
`define R_RSTEP 8'h10

// ==========================================================
// Field positions
`define B_MAN 4
`define B_MIN 5
`define B_STRT 6
`define B_MAX 7
`define B_MINBIT 4
`define B_STEPEN 6
`define B_TREE 0
`define B_FAULT1 1
`define B_FAULT2 0

// ==========================================================
// Timing
`define CLK_NS 20
`define MS_NS 1000000
`define LOOP_MS 250
`define RETRY_MS 2000
`define WAIT_MS 60000
`define MAX_RETRY 3'd5
`define FULL 8'hFF

`endif

// *** dv/fan_model.sv ***
/*
 Behavioural fan: tach output that toggles while driven.
 Assumes the tach line has a pull-up, so a stopped fan reads high.
*/
`timescale 1ns/10ps

module fan_model #(
  parameter HALF = 20
) (
  input wire ref_clk,
  input wire [7:0] drive,
  input wire stuck,
  output reg tach
);
  reg [7:0] cnt_r;
  initial begin
    tach = 1'b1;
    cnt_r = 8'h00;
  end
  // ==========
  // Rotation
  always @(posedge ref_clk) begin
    if (drive == 8'h00 || stuck) begin
      tach <= 1'b1;
      cnt_r <= 8'h00;
    end else if (cnt_r == HALF - 1) begin
      cnt_r <= 8'h00;
      tach <= ~tach;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
endmodule

// *** dv/fan_ctrl_asserts.sv ***
/*
 Port checker for fan_ctrl.
 Assumes register shadows start from the design's reset values.
*/
`timescale 1ns/10ps
`include "fan_ctrl_defines.vh"

module fan_ctrl_asserts (
  input wire ref_clk,
  input wire sys_rst,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr_en,
  input wire rd_en,
  input wire [7:0] rdata,
  input wire [7:0] thermistor_in_1,
  input wire [7:0] thermistor_in_2,
  input wire [7:0] remote_temp_1,
  input wire [7:0] local_temp,
  input wire tach_in_1,
  input wire tach_in_2,
  input wire processor_hot_input,
  input wire [7:0] drive_out_1,
  input wire [7:0] drive_out_2,
  input wire fan1_power_on,
  input wire stall_fault_pin,
  input wire tree_test_out
);
  reg [7:0] cfg1_r;
  reg [7:0] man1_r;
  reg [7:0] hold1_r;
  reg [7:0] lim_r;
  reg test_r;
  reg [31:0] temps_r;
  reg [3:0] quiet_r;
  wire [31:0] temps = {thermistor_in_1, thermistor_in_2, remote_temp_1, local_temp};
  wire settled = quiet_r >= 4'h3 && temps == temps_r;
  wire hot = thermistor_in_1 >= lim_r || thermistor_in_2 >= lim_r || remote_temp_1 >= lim_r || local_temp >= lim_r;
  wire tree_exp = test_r & (tach_in_1 ^ tach_in_2 ^ processor_hot_input);
  // ==========
  // Shadows
  always @(posedge ref_clk) begin
    temps_r <= temps;
    if (sys_rst) begin
      cfg1_r <= `R_LOOP;
      man1_r <= 8'h00;
      hold1_r <= `R_HOLD;
      lim_r <= `R_OTLIM;
      test_r <= 1'b0;
      quiet_r <= 4'h0;
    end else begin
      quiet_r <= (wr_en || temps != temps_r) ? 4'h0 : quiet_r + {3'h0, quiet_r != 4'hF};
      if (wr_en && addr == `A_LOOP1) cfg1_r <= wdata;
      if (wr_en && addr == `A_MAN1) man1_r <= wdata;
      if (wr_en && addr == `A_HOLD1) hold1_r <= wdata;
      if (wr_en && addr == `A_OTLIM) lim_r <= wdata;
      if (wr_en && addr == `A_TEST) test_r <= wdata[0];
    end
  end
  // ==========
  // Assertions
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  power_on_a: assert property (fan1_power_on == (drive_out_1 != 8'h00))
    else $error("fan 1 power-on disagrees with drive");
  max_drive_a: assert property (settled && cfg1_r[7] |-> drive_out_1 == 8'hFF)
    else $error("full drive override missing");
  hold_level_a: assert property (settled && cfg1_r[7:5] == 3'b001 && drive_out_1 != 8'hFF |-> drive_out_1 == hold1_r)
    else $error("minimum override not at hold level");
  man_drive_a: assert property (settled && cfg1_r[7:4] == 4'h1 && drive_out_1 != 8'hFF |-> drive_out_1 == man1_r)
    else $error("manual drive not applied");
  ot_full_a: assert property (settled && hot |-> drive_out_1 == 8'hFF && drive_out_2 == 8'hFF)
    else $error("over-temperature did not force full drive");
  tree_out_a: assert property (!$past(sys_rst) |-> tree_test_out == $past(tree_exp))
    else $error("tree test output wrong");
  rdata_idle_a: assert property (!$past(rd_en) |-> rdata == 8'h00)
    else $error("read data outside read slot");
  lock_zero_a: assert property ($rose(stall_fault_pin) |-> ##[0:1] (drive_out_1 == 8'h00 || drive_out_2 == 8'h00))
    else $error("lock pin raised with drive on");
endmodule

bind fan_ctrl fan_ctrl_asserts u_fan_ctrl_asserts (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
  .rdata(rdata), .thermistor_in_1(thermistor_in_1), .thermistor_in_2(thermistor_in_2),
  .remote_temp_1(remote_temp_1), .local_temp(local_temp), .tach_in_1(tach_in_1), .tach_in_2(tach_in_2),
  .processor_hot_input(processor_hot_input), .drive_out_1(drive_out_1), .drive_out_2(drive_out_2),
  .fan1_power_on(fan1_power_on), .stall_fault_pin(stall_fault_pin), .tree_test_out(tree_test_out)
);

// *** dv/fan_ctrl_test.sv ***
/*
 Self-checking bench for fan_ctrl with two fan models.
 Assumes MS_CYC of 2, so 250 ms is 500 cycles.
*/
`timescale 1ns/10ps
`define CHK(n, e, g) begin comparisons = comparisons + 1; if ((g) !== (e)) begin num_errors = num_errors + 1; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end

module fan_ctrl_test;
  reg ref_clk, sys_rst, wr_en, rd_en, processor_hot_input, stuck_1;
  reg [7:0] addr, wdata, th1, th2, rem1, loc;
  wire [7:0] rdata, drive_out_1, drive_out_2;
  wire fan1_power_on, stall_fault_pin, tree_test_out, tach_1, tach_2;
  integer num_errors, comparisons, i, c;
  reg [7:0] cfgs [0:3];
  reg [7:0] exps [0:3];
  fan_ctrl #(.MS_CYC(2)) u_fan_ctrl (.ref_clk(ref_clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .thermistor_in_1(th1), .thermistor_in_2(th2),
    .remote_temp_1(rem1), .local_temp(loc), .tach_in_1(tach_1), .tach_in_2(tach_2),
    .processor_hot_input(processor_hot_input), .drive_out_1(drive_out_1), .drive_out_2(drive_out_2),
    .fan1_power_on(fan1_power_on), .stall_fault_pin(stall_fault_pin), .tree_test_out(tree_test_out));
  fan_model u_fan_model_1 (.ref_clk(ref_clk), .drive(drive_out_1), .stuck(stuck_1), .tach(tach_1));
  fan_model u_fan_model_2 (.ref_clk(ref_clk), .drive(drive_out_2), .stuck(1'b0), .tach(tach_2));
  // ==========
  // Tasks
  task end_of_test;
    begin
      if (num_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge ref_clk);
      wr_en <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge ref_clk);
      wr_en <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      @(posedge ref_clk);
      rd_en <= 1'b1;
      addr <= a;
      @(posedge ref_clk);
      rd_en <= 1'b0;
      #1;
      `CHK("rdata", e, rdata)
    end
  endtask
  task waitd(input sel, input [7:0] e, input integer n);
    begin
      c = 0;
      while ((sel ? drive_out_2 : drive_out_1) !== e && c < n) begin
        @(posedge ref_clk);
        #1;
        c = c + 1;
      end
      `CHK("drive", e, sel ? drive_out_2 : drive_out_1)
    end
  endtask
  task wchg;
    reg [7:0] v;
    begin
      v = drive_out_1;
      c = 0;
      while (drive_out_1 === v && c < 700) begin
        @(posedge ref_clk);
        #1;
        c = c + 1;
      end
    end
  endtask
  // ==========
  // Clock, reset and watchdog
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (100000) @(posedge ref_clk);
    num_errors = num_errors + 1;
    end_of_test;
  end
  // ==========
  // Tests
  initial begin
    {sys_rst, wr_en, rd_en, processor_hot_input, stuck_1} = 5'b10000;
    {addr, wdata, th1, th2, rem1, loc} = {8'h00, 8'h00, 8'h20, 8'h20, 8'h20, 8'h20};
    num_errors = 0;
    comparisons = 0;
    {cfgs[0], cfgs[1], cfgs[2], cfgs[3]} = {8'h1C, 8'h3F, 8'h7F, 8'hFF};
    {exps[0], exps[1], exps[2], exps[3]} = {8'h33, 8'h40, 8'h80, 8'hFF};
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(8'h05, 8'h0C);
    rd(8'h06, 8'h0C);
    rd(8'h39, 8'h05);
    rd(8'h07, 8'h00);
    wr(8'h38, 8'hFF);
    rd(8'h38, 8'h3F);
    wr(8'h38, 8'h00);
    wr(8'h34, 8'h00);
    wr(8'h35, 8'h00);
    wr(8'h6B, 8'h33);
    for (i = 0; i < 4; i = i + 1) begin
      wr(8'h05, cfgs[i]);
      repeat (4) @(posedge ref_clk);
      #1;
      `CHK("override drive", exps[i], drive_out_1)
      `CHK("power on", 1'b1, fan1_power_on)
    end
    wr(8'h06, 8'h80);
    waitd(1, 8'hFF, 4);
    wr(8'h06, 8'h04);
    wr(8'h05, 8'h10);
    wr(8'h6B, 8'h00);
    waitd(0, 8'h00, 4);
    `CHK("power on", 1'b0, fan1_power_on)
    wr(8'h05, 8'h08);
    loc <= 8'h2C;
    waitd(0, 8'h80, 10);
    `CHK("power on", 1'b1, fan1_power_on)
    waitd(0, 8'h40, 200);
    waitd(0, 8'h66, 600);
    wr(8'h05, 8'h0C);
    rem1 <= 8'h30;
    waitd(0, 8'h8C, 600);
    waitd(1, 8'h8C, 1200);
    wr(8'h34, 8'h70);
    waitd(0, 8'h70, 10);
    @(posedge ref_clk);
    loc <= 8'h64;
    waitd(0, 8'hFF, 4);
    waitd(1, 8'hFF, 4);
    @(posedge ref_clk);
    loc <= 8'h61;
    repeat (20) @(posedge ref_clk);
    `CHK("hysteresis drive", 8'hFF, drive_out_1)
    loc <= 8'h5F;
    waitd(0, 8'h70, 10);
    waitd(1, 8'h8C, 10);
    wr(8'h34, 8'h00);
    waitd(0, 8'hFF, 600);
    wr(8'h36, 8'h42);
    loc <= 8'h2C;
    rem1 <= 8'h20;
    wchg;
    `CHK("step drive", 8'hFC, drive_out_1)
    wchg;
    `CHK("step period", 500, c)
    `CHK("step drive", 8'hF9, drive_out_1)
    wr(8'h36, 8'h00);
    waitd(0, 8'h66, 600);
    wr(8'h03, 8'h10);
    loc <= 8'h20;
    waitd(0, 8'h40, 600);
    repeat (1500) @(posedge ref_clk);
    #1;
    `CHK("minimum drive", 8'h40, drive_out_1)
    wr(8'h03, 8'h00);
    waitd(0, 8'h00, 600);
    `CHK("power on", 1'b0, fan1_power_on)
    wr(8'h38, 8'h01);
    stuck_1 <= 1'b1;
    loc <= 8'h2C;
    waitd(0, 8'h80, 10);
    repeat (150) @(posedge ref_clk);
    rd(8'h10, 8'h00);
    repeat (100) @(posedge ref_clk);
    rd(8'h10, 8'h02);
    rd(8'h10, 8'h00);
    waitd(0, 8'h90, 4100);
    c = 0;
    while (stall_fault_pin !== 1'b1 && c < 20100) begin
      @(posedge ref_clk);
      #1;
      c = c + 1;
    end
    `CHK("lock pin", 1'b1, stall_fault_pin)
    `CHK("lock drive", 8'h00, drive_out_1)
    wr(8'h05, 8'h80);
    waitd(0, 8'hFF, 4);
    @(posedge ref_clk);
    #1;
    `CHK("lock pin", 1'b0, stall_fault_pin)
    wr(8'h02, 8'h02);
    wr(8'h13, 8'h02);
    wr(8'h42, 8'h01);
    for (i = 0; i < 2; i = i + 1) begin
      @(posedge ref_clk);
      processor_hot_input <= ~processor_hot_input;
      repeat (3) @(posedge ref_clk);
      #1;
      `CHK("tree out", tach_1 ^ tach_2 ^ processor_hot_input, tree_test_out)
    end
    wr(8'h42, 8'h00);
    processor_hot_input <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    `CHK("tree out", 1'b0, tree_test_out)
    end_of_test;
  end
endmodule
